// File: common/flash_seq_cfg.svh
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

`define FLASH_CMD_ADDR 8'hD5
`define FLASH_DATA_ADDR 8'hD6
`define FLASH_IDLE_BIT 7
`define FLASH_FAULT_BIT 6
`define FLASH_CMD_MSB 3
`define FLASH_CMD_LSB 0
`define FLASH_IDLE_RST 1'b1
`define FLASH_FAULT_RST 1'b0
`define FLASH_ERASED 8'hFF
`define FLASH_OPT_WDT_BIT 3
`define FLASH_OPT_LOC 8'hFC
`define FLASH_SIG_MAKER_LOC 8'h30
`define FLASH_SIG_PART_LOC 8'h31
`define FLASH_SIG_EXT_LOC 8'h60
`define FLASH_LOCK_LOC 8'h40
`define FLASH_ENC_TOP 8'h3F
`define FLASH_LB1_BIT 3
`define FLASH_LB2_BIT 4
`define FLASH_LB3_BIT 5
`define FLASH_UPPER_SEL 3'h1
`define FLASH_RESET_VECTOR 16'h0000
`define FLASH_VECTOR_SPAN 128
`define FLASH_CLK_PERIOD_NS 10
`define FLASH_IDLE_FALL_MAX_NS 1000
`define FLASH_IDLE_FALL_MAX_CYCLES (`FLASH_IDLE_FALL_MAX_NS / `FLASH_CLK_PERIOD_NS)
`define FLASH_PROG_TIME_NS 20000
`define FLASH_ERASE_TIME_NS 10000000
`define FLASH_PROG_CYCLES ((`FLASH_PROG_TIME_NS + `FLASH_CLK_PERIOD_NS - 1) / `FLASH_CLK_PERIOD_NS)
`define FLASH_ERASE_CYCLES ((`FLASH_ERASE_TIME_NS + `FLASH_CLK_PERIOD_NS - 1) / `FLASH_CLK_PERIOD_NS)

`endif

// File: common/flash_seq_pkg.sv
package flash_seq_pkg;

  typedef enum logic [3:0] {
    CMD_READ = 4'h0,
    CMD_VER_OPT = 4'h1,
    CMD_VER_SEC = 4'h2,
    CMD_VER_UP = 4'h3,
    CMD_RSVD_4 = 4'h4,
    CMD_RSVD_5 = 4'h5,
    CMD_RSVD_6 = 4'h6,
    CMD_RSVD_7 = 4'h7,
    CMD_RSVD_8 = 4'h8,
    CMD_WR_OPT = 4'h9,
    CMD_WR_SEC = 4'hA,
    CMD_WR_UP = 4'hB,
    CMD_ER_OPT = 4'hC,
    CMD_ER_SEC = 4'hD,
    CMD_ER_UP = 4'hE,
    CMD_SYS_RST = 4'hF
  } cmd_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_READ = 2'b01,
    OP_PROG = 2'b10,
    OP_ERASE = 2'b11
  } op_t;

  typedef enum logic [1:0] {
    P_COLLECT = 2'b00,
    P_BUSY = 2'b01,
    P_READ = 2'b10,
    P_DONE = 2'b11
  } phase_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_READ = 2'b01,
    E_PROG = 2'b10,
    E_ERASE = 2'b11
  } eng_state_t;

endpackage : flash_seq_pkg

// File: common/flash_op_if.sv
`timescale 1ns/1ps
interface flash_op_if;
  import flash_seq_pkg::*;
  logic start;
  op_t op;
  logic bank;
  logic [12:0] addr;
  logic [7:0] wdata;
  logic done;
  logic fail;
  logic [7:0] rdata;
  modport seq (output start, op, bank, addr, wdata, input done, fail, rdata);
  modport eng (input start, op, bank, addr, wdata, output done, fail, rdata);
endinterface : flash_op_if

// File: rtl/flash_bank_engine.sv
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
module flash_bank_engine #(
  parameter int PROG_CYCLES = `FLASH_PROG_CYCLES,
  parameter int ERASE_CYCLES = `FLASH_ERASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  flash_op_if.eng op,
  output logic [12:0] o_flash_addr,
  output logic [7:0] o_flash_wdata,
  output logic o_flash_rd,
  output logic o_flash_prog,
  output logic o_flash_erase,
  input wire logic [7:0] i_flash_rdata,
  input wire logic i_flash_fail
);
  import flash_seq_pkg::*;

  localparam int CW = $clog2(ERASE_CYCLES + PROG_CYCLES + 2);
  localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);
  localparam logic [CW-1:0] ERASE_LAST = CW'(ERASE_CYCLES - 1);

  eng_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic bank_q;
  logic done_q;
  logic fail_q;
  logic [7:0] rdata_q;
  logic abort;
  logic timed_out;

  // Only the bank macro can report a failure
  assign abort = bank_q && i_flash_fail && (state_q == E_PROG || state_q == E_ERASE);
  assign timed_out = (state_q == E_PROG && cnt_q == PROG_LAST) ||
                     (state_q == E_ERASE && cnt_q == ERASE_LAST);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= E_IDLE;
    end else begin
      unique case (state_q)
        E_IDLE: begin
          if (op.start) begin
            unique case (op.op)
              OP_NONE: state_q <= E_IDLE;
              OP_READ: state_q <= E_READ;
              OP_PROG: state_q <= E_PROG;
              OP_ERASE: state_q <= E_ERASE;
            endcase
          end
        end
        E_READ: state_q <= E_IDLE;
        E_PROG, E_ERASE: begin
          if (abort || timed_out) begin
            state_q <= E_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= '0;
    end else if (state_q == E_IDLE) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      bank_q <= 1'b0;
      o_flash_addr <= '0;
      o_flash_wdata <= 8'h00;
    end else if (state_q == E_IDLE && op.start) begin
      bank_q <= op.bank;
      o_flash_addr <= op.addr;
      o_flash_wdata <= op.wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      done_q <= (state_q == E_READ) || abort || timed_out;
      fail_q <= abort;
      if (state_q == E_READ) begin
        rdata_q <= i_flash_rdata;
      end
    end
  end

  assign o_flash_rd = (state_q == E_READ) && bank_q;
  assign o_flash_prog = (state_q == E_PROG) && bank_q;
  assign o_flash_erase = (state_q == E_ERASE) && bank_q;
  assign op.done = done_q;
  assign op.fail = fail_q;
  assign op.rdata = rdata_q;
endmodule : flash_bank_engine

// File: rtl/flash_iap_security_sequencer.sv
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
module flash_iap_security_sequencer #(
  parameter int PROG_CYCLES = `FLASH_PROG_CYCLES,
  parameter int ERASE_CYCLES = `FLASH_ERASE_CYCLES,
  // Arbitrary identification values
  parameter logic [7:0] MAKER_CODE = 8'hA5,
  parameter logic [7:0] PART_CODE = 8'h3C,
  parameter logic [7:0] EXT_CODE = 8'h02
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_power_on,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_timed_access_ok,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_loader_mode,
  input wire logic i_parallel_mode,
  input wire logic i_prog_rd,
  input wire logic i_prog_sig,
  input wire logic [7:0] i_prog_addr,
  input wire logic [7:0] i_prog_code_data,
  output logic [7:0] o_prog_rdata,
  output logic o_prog_write_ok,
  input wire logic i_external_access_pin,
  output logic o_external_access_eff,
  output logic o_block_ext_code_read,
  output logic o_block_ext_data_read,
  output logic o_block_ext_exec,
  output logic o_wdt_por_enable,
  output logic o_upper_exec_ok,
  output logic o_sys_reset_req,
  output logic [15:0] o_reset_vector,
  output logic [7:0] o_vector_span,
  output flash_seq_pkg::cmd_t o_flash_command_field,
  output logic [12:0] o_flash_addr,
  output logic [7:0] o_flash_wdata,
  output logic o_flash_rd,
  output logic o_flash_prog,
  output logic o_flash_erase,
  input wire logic [7:0] i_flash_rdata,
  input wire logic i_flash_fail
);
  import flash_seq_pkg::*;

  flash_op_if op_bus();

  logic [7:0] enc_q [64];
  logic [2:0] lock_q;
  logic [7:0] opt_q;
  cmd_t cmd_q;
  cmd_t wcmd;
  phase_t phase_q;
  logic flash_idle_flag_q;
  logic flash_fault_flag_q;
  logic [1:0] cnt_q;
  logic [7:0] hi_q;
  logic [7:0] data_q;
  logic [7:0] rdata_q;
  logic [7:0] prog_rdata_q;
  logic start_q;
  op_t op_q;
  logic bank_q;
  logic [12:0] op_addr_q;
  logic [7:0] op_wdata_q;
  logic sys_rst_q;
  logic ea_lat_q;
  logic ea_cap_q;
  logic enc_active;
  logic lvl2;
  logic lvl3;
  logic lvl4;
  logic prog_mode;
  logic cmd_acc;
  logic dp_wr;
  logic in_upper;
  logic erase_go;
  logic write_go;
  logic read_go;
  logic bad_addr;
  logic op_end;
  logic op_ok;

  function automatic logic [7:0] encrypt(input logic [7:0] d, input logic [7:0] k,
                                         input logic on);
    encrypt = on ? ~(d ^ k) : d;
  endfunction : encrypt

  function automatic logic [7:0] opt_read(input logic [7:0] o);
    opt_read = 8'hFF;
    opt_read[`FLASH_OPT_WDT_BIT] = o[`FLASH_OPT_WDT_BIT];
  endfunction : opt_read

  function automatic logic [7:0] sec_read(input logic [7:0] a, input logic [2:0] lb,
                                          input logic [7:0] key);
    sec_read = `FLASH_ERASED;
    if (a == `FLASH_LOCK_LOC) begin
      sec_read[`FLASH_LB1_BIT] = lb[0];
      sec_read[`FLASH_LB2_BIT] = lb[1];
      sec_read[`FLASH_LB3_BIT] = lb[2];
    end else if (a <= `FLASH_ENC_TOP) begin
      sec_read = key;
    end
  endfunction : sec_read

  always_comb begin
    enc_active = 1'b0;
    for (int i = 0; i < 64; i++) begin
      if (enc_q[i] != `FLASH_ERASED) begin
        enc_active = 1'b1;
      end
    end
  end

  // level one when all locks high
  assign lvl2 = ~&lock_q;
  assign lvl3 = ~lock_q[1] | ~lock_q[2];
  assign lvl4 = ~lock_q[2];
  assign prog_mode = i_loader_mode | i_parallel_mode;

  assign wcmd = cmd_t'(i_sfr_wdata[`FLASH_CMD_MSB:`FLASH_CMD_LSB]);
  assign cmd_acc = i_sfr_wr && i_sfr_addr == `FLASH_CMD_ADDR && i_timed_access_ok &&
                   phase_q != P_BUSY && phase_q != P_READ;
  assign dp_wr = i_sfr_wr && i_sfr_addr == `FLASH_DATA_ADDR && cmd_q != CMD_READ &&
                 phase_q == P_COLLECT;
  assign in_upper = hi_q[7:5] == `FLASH_UPPER_SEL;

  assign erase_go = cmd_acc && (wcmd == CMD_ER_OPT || wcmd == CMD_ER_SEC ||
                                wcmd == CMD_ER_UP);
  assign write_go = dp_wr && ((cmd_q == CMD_WR_OPT && cnt_q == 2'd0) ||
                              (cmd_q == CMD_WR_SEC && cnt_q == 2'd1) ||
                              (cmd_q == CMD_WR_UP && cnt_q == 2'd2 && in_upper));
  assign read_go = dp_wr && cmd_q == CMD_VER_UP && cnt_q == 2'd1 && in_upper;
  assign bad_addr = dp_wr && !in_upper &&
                    ((cmd_q == CMD_WR_UP && cnt_q == 2'd2) ||
                     (cmd_q == CMD_VER_UP && cnt_q == 2'd1));
  assign op_end = op_bus.done && phase_q == P_BUSY;
  assign op_ok = op_end && !op_bus.fail;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cmd_q <= CMD_READ;
    end else if (cmd_acc) begin
      cmd_q <= wcmd;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      phase_q <= P_COLLECT;
      cnt_q <= 2'd0;
    end else if (cmd_acc) begin
      cnt_q <= 2'd0;
      if (erase_go) begin
        phase_q <= P_BUSY;
      end else if (wcmd == CMD_VER_OPT || wcmd == CMD_SYS_RST) begin
        phase_q <= P_DONE;
      end else begin
        phase_q <= P_COLLECT;
      end
    end else if (dp_wr) begin
      cnt_q <= cnt_q + 2'd1;
      if (write_go) begin
        phase_q <= P_BUSY;
      end else if (read_go) begin
        phase_q <= P_READ;
      end else if (bad_addr || cmd_q == CMD_VER_SEC) begin
        phase_q <= P_DONE;
      end
    end else if (op_bus.done && (phase_q == P_BUSY || phase_q == P_READ)) begin
      phase_q <= P_DONE;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hi_q <= 8'h00;
    end else if (dp_wr && cnt_q == 2'd0) begin
      hi_q <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      start_q <= 1'b0;
      op_q <= OP_NONE;
      bank_q <= 1'b0;
      op_addr_q <= '0;
      op_wdata_q <= 8'h00;
    end else begin
      start_q <= erase_go || write_go || read_go;
      if (erase_go) begin
        op_q <= OP_ERASE;
        bank_q <= wcmd == CMD_ER_UP;
      end else if (read_go) begin
        op_q <= OP_READ;
        bank_q <= 1'b1;
        op_addr_q <= {hi_q[4:0], i_sfr_wdata};
      end else if (write_go) begin
        op_q <= OP_PROG;
        bank_q <= cmd_q == CMD_WR_UP;
        op_wdata_q <= i_sfr_wdata;
        if (cmd_q == CMD_WR_UP) begin
          op_addr_q <= {hi_q[4:0], op_addr_q[7:0]};
        end
      end else if (dp_wr && cnt_q == 2'd1) begin
        op_addr_q <= {op_addr_q[12:8], i_sfr_wdata};
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      flash_idle_flag_q <= `FLASH_IDLE_RST;
    end else if (op_end) begin
      flash_idle_flag_q <= 1'b1;
    end else if (erase_go || write_go) begin
      flash_idle_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      flash_fault_flag_q <= `FLASH_FAULT_RST;
    end else if ((op_end && op_bus.fail) || bad_addr) begin
      flash_fault_flag_q <= 1'b1;
    end else if (cmd_acc) begin
      flash_fault_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      data_q <= 8'h00;
    end else if (cmd_acc && wcmd == CMD_VER_OPT) begin
      data_q <= opt_read(opt_q);
    end else if (dp_wr && cmd_q == CMD_VER_SEC) begin
      data_q <= sec_read(i_sfr_wdata, lock_q, enc_q[i_sfr_wdata[5:0]]);
    end else if (op_bus.done && phase_q == P_READ) begin
      data_q <= encrypt(op_bus.rdata, enc_q[op_addr_q[5:0]], enc_active);
    end else if (dp_wr) begin
      data_q <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
    end else if (i_sfr_addr == `FLASH_CMD_ADDR) begin
      rdata_q <= {flash_idle_flag_q, flash_fault_flag_q, 2'b00, cmd_q};
    end else if (i_sfr_addr == `FLASH_DATA_ADDR) begin
      rdata_q <= data_q;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Security flash survives system resets; only power-on, CMD_ER_OPT and CMD_ER_SEC clear it
  always_ff @(posedge i_clk or posedge i_power_on) begin
    if (i_power_on) begin
      lock_q <= 3'h7;
      opt_q <= `FLASH_ERASED;
      for (int i = 0; i < 64; i++) begin
        enc_q[i] <= `FLASH_ERASED;
      end
    end else if (op_ok) begin
      unique case (cmd_q)
        CMD_WR_OPT: opt_q <= opt_q & op_wdata_q;
        CMD_WR_SEC: begin
          if (hi_q == `FLASH_LOCK_LOC) begin
            lock_q <= lock_q & {op_wdata_q[`FLASH_LB3_BIT], op_wdata_q[`FLASH_LB2_BIT],
                                op_wdata_q[`FLASH_LB1_BIT]};
          end else if (hi_q <= `FLASH_ENC_TOP) begin
            enc_q[hi_q[5:0]] <= enc_q[hi_q[5:0]] & op_wdata_q;
          end
        end
        CMD_ER_OPT: opt_q <= `FLASH_ERASED;
        CMD_ER_SEC: begin
          lock_q <= 3'h7;
          for (int i = 0; i < 64; i++) begin
            enc_q[i] <= `FLASH_ERASED;
          end
        end
        default: lock_q <= lock_q;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      prog_rdata_q <= 8'h00;
    end else if (i_prog_rd && prog_mode) begin
      if (i_prog_sig) begin
        unique case (i_prog_addr)
          `FLASH_SIG_MAKER_LOC: prog_rdata_q <= MAKER_CODE;
          `FLASH_SIG_PART_LOC: prog_rdata_q <= PART_CODE;
          `FLASH_SIG_EXT_LOC: prog_rdata_q <= EXT_CODE;
          `FLASH_OPT_LOC: prog_rdata_q <= opt_read(opt_q);
          default: prog_rdata_q <= `FLASH_ERASED;
        endcase
      end else if (lvl3) begin
        prog_rdata_q <= `FLASH_ERASED;
      end else begin
        prog_rdata_q <= encrypt(i_prog_code_data, enc_q[i_prog_addr[5:0]], enc_active);
      end
    end
  end

  // access pin caught after reset release
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ea_lat_q <= 1'b0;
      ea_cap_q <= 1'b0;
    end else if (!ea_cap_q) begin
      ea_lat_q <= i_external_access_pin;
      ea_cap_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sys_rst_q <= 1'b0;
    end else begin
      sys_rst_q <= cmd_acc && wcmd == CMD_SYS_RST;
    end
  end

  assign op_bus.start = start_q;
  assign op_bus.op = op_q;
  assign op_bus.bank = bank_q;
  assign op_bus.addr = op_addr_q;
  assign op_bus.wdata = op_wdata_q;

  flash_bank_engine #(
    .PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
  ) u_engine (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .op(op_bus.eng),
    .o_flash_addr(o_flash_addr),
    .o_flash_wdata(o_flash_wdata),
    .o_flash_rd(o_flash_rd),
    .o_flash_prog(o_flash_prog),
    .o_flash_erase(o_flash_erase),
    .i_flash_rdata(i_flash_rdata),
    .i_flash_fail(i_flash_fail)
  );

  assign o_sfr_rdata = rdata_q;
  assign o_prog_rdata = prog_rdata_q;
  assign o_prog_write_ok = prog_mode && !lvl2;
  assign o_block_ext_code_read = lvl2;
  assign o_external_access_eff = lvl2 ? ea_lat_q : i_external_access_pin;
  assign o_block_ext_data_read = lvl3;
  assign o_block_ext_exec = lvl4;
  assign o_wdt_por_enable = ~opt_q[`FLASH_OPT_WDT_BIT];
  assign o_upper_exec_ok = cmd_q == CMD_READ;
  assign o_sys_reset_req = sys_rst_q;
  assign o_reset_vector = `FLASH_RESET_VECTOR;
  assign o_vector_span = 8'(`FLASH_VECTOR_SPAN);
  assign o_flash_command_field = cmd_q;
endmodule : flash_iap_security_sequencer

// File: dv/flash_seq_props.sv
`timescale 1ns/1ps
module flash_seq_props (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_timed_access_ok,
  input wire logic i_external_access_pin,
  input wire logic o_external_access_eff,
  input wire logic o_block_ext_code_read,
  input wire logic o_block_ext_data_read,
  input wire logic o_block_ext_exec,
  input wire logic o_prog_write_ok,
  input wire logic o_upper_exec_ok,
  input wire logic [15:0] o_reset_vector,
  input wire logic [7:0] o_vector_span,
  input wire flash_seq_pkg::cmd_t o_flash_command_field,
  input wire logic o_flash_prog,
  input wire logic o_flash_erase,
  input wire logic o_flash_rd
);
  import flash_seq_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic cw;
  logic dw;
  assign cw = i_sfr_wr && i_sfr_addr == 8'hD5;
  assign dw = i_sfr_wr && i_sfr_addr == 8'hD6;
  property p_lvl4; o_block_ext_exec |-> o_block_ext_data_read; endproperty
  a_lvl4: assert property (p_lvl4)
    else $error("exec block without data block");
  property p_lvl3; o_block_ext_data_read |-> o_block_ext_code_read; endproperty
  a_lvl3: assert property (p_lvl3)
    else $error("data block without code block");
  property p_lvl2; o_prog_write_ok |-> !o_block_ext_code_read; endproperty
  a_lvl2: assert property (p_lvl2)
    else $error("programming allowed while locked");
  property p_ea; !o_block_ext_code_read |-> o_external_access_eff == i_external_access_pin;
  endproperty
  a_ea: assert property (p_ea)
    else $error("access pin not live while unlocked");
  property p_vec; o_reset_vector == 16'h0000 && o_vector_span == 8'h80; endproperty
  a_vec: assert property (p_vec)
    else $error("vector placement wrong");
  property p_exec; o_upper_exec_ok == (o_flash_command_field == CMD_READ); endproperty
  a_exec: assert property (p_exec)
    else $error("upper exec enable wrong");
  property p_untimed; cw && !i_timed_access_ok |=> $stable(o_flash_command_field); endproperty
  a_untimed: assert property (p_untimed)
    else $error("untimed command write taken");
  property p_busy; (o_flash_prog || o_flash_erase) && cw |=> $stable(o_flash_command_field);
  endproperty
  a_busy: assert property (p_busy)
    else $error("command taken while busy");
  property p_rdmode;
    o_flash_command_field == CMD_READ && dw |=> (!o_flash_prog && !o_flash_erase && !o_flash_rd)[*2];
  endproperty
  a_rdmode: assert property (p_rdmode)
    else $error("data port started an operation");
  c_prog: cover property (o_flash_prog && cw);
  c_erase: cover property (o_flash_erase);
  c_lock: cover property (o_block_ext_data_read);
endmodule : flash_seq_props

bind flash_iap_security_sequencer flash_seq_props i_props (
  .i_clk, .i_reset, .i_sfr_addr, .i_sfr_wr, .i_timed_access_ok, .i_external_access_pin,
  .o_external_access_eff, .o_block_ext_code_read, .o_block_ext_data_read, .o_block_ext_exec,
  .o_prog_write_ok, .o_upper_exec_ok, .o_reset_vector, .o_vector_span, .o_flash_command_field,
  .o_flash_prog, .o_flash_erase, .o_flash_rd);

// File: dv/flash_upper_model.sv
`timescale 1ns/1ps
module flash_upper_model (
  input wire logic i_clk,
  input wire logic [12:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  input wire logic i_prog,
  input wire logic i_erase,
  input wire logic i_inject,
  output logic [7:0] o_rdata,
  output logic o_fail
);
  logic [7:0] mem [8192];
  logic prog_q = 0;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  always @(posedge i_clk) begin
    prog_q <= i_prog;
    if (i_prog && !prog_q) mem[i_addr] <= mem[i_addr] & i_wdata;
    if (i_erase) foreach (mem[i]) mem[i] <= 8'hFF;
  end
  // Data inverted when not read
  assign o_rdata = i_rd ? mem[i_addr] : ~mem[i_addr];
  assign o_fail = i_inject && (i_prog || i_erase);
endmodule : flash_upper_model

// File: dv/flash_iap_security_sequencer_tb_top.sv
`timescale 1ns/1ps
module flash_iap_security_sequencer_tb_top;
  import flash_seq_pkg::*;
  // Arbitrary identification values
  localparam logic [7:0] MK = 8'h5A, PT = 8'hC3, EX = 8'h17;
  logic i_clk = 0, i_reset = 1, i_power_on = 1, i_sfr_wr = 0, i_timed_access_ok = 0;
  logic i_parallel_mode = 0, i_prog_rd = 0, i_prog_sig = 0, i_external_access_pin = 1, inj = 0;
  logic i_loader_mode = 0, srq;
  logic [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, i_prog_addr = 0, i_prog_code_data = 0;
  logic [7:0] o_sfr_rdata, o_prog_rdata, i_flash_rdata, o_flash_wdata, v, d;
  logic [12:0] o_flash_addr;
  logic [15:0] a;
  logic o_prog_write_ok, o_block_ext_code_read, o_block_ext_data_read, o_block_ext_exec;
  logic o_wdt_por_enable, o_flash_rd, o_flash_prog, o_flash_erase, i_flash_fail;
  logic [7:0] sa [4] = '{8'h30, 8'h31, 8'h60, 8'hFC};
  logic [7:0] se [4] = '{MK, PT, EX, 8'hF7};
  int fail_count = 0, compares = 0, cyc = 0;
  always #5 i_clk = ~i_clk;
  flash_iap_security_sequencer #(.PROG_CYCLES(16), .ERASE_CYCLES(24), .MAKER_CODE(MK),
    .PART_CODE(PT), .EXT_CODE(EX)) i_dut (
    .i_clk, .i_reset, .i_power_on, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_timed_access_ok,
    .o_sfr_rdata, .i_loader_mode, .i_parallel_mode, .i_prog_rd, .i_prog_sig, .i_prog_addr,
    .i_prog_code_data, .o_prog_rdata, .o_prog_write_ok, .i_external_access_pin,
    .o_external_access_eff(), .o_block_ext_code_read, .o_block_ext_data_read, .o_block_ext_exec,
    .o_wdt_por_enable, .o_upper_exec_ok(), .o_sys_reset_req(srq), .o_reset_vector(),
    .o_vector_span(), .o_flash_command_field(), .o_flash_addr, .o_flash_wdata, .o_flash_rd,
    .o_flash_prog, .o_flash_erase, .i_flash_rdata, .i_flash_fail);
  flash_upper_model i_mem (.i_clk, .i_addr(o_flash_addr), .i_wdata(o_flash_wdata),
    .i_rd(o_flash_rd), .i_prog(o_flash_prog), .i_erase(o_flash_erase), .i_inject(inj),
    .o_rdata(i_flash_rdata), .o_fail(i_flash_fail));
  function automatic logic [7:0] st(input logic i, input logic f, input logic [3:0] c);
    return {i, f, 2'b00, c};
  endfunction : st
  function automatic logic [7:0] xn(input logic [7:0] c, input logic [7:0] k);
    return ~(c ^ k);
  endfunction : xn
  task automatic conclude();
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      $display("ERROR %s exp %h got %h", n, e, s);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt, input logic t);
    @(posedge i_clk);
    i_sfr_addr <= ad;
    i_sfr_wdata <= dt;
    i_timed_access_ok <= t;
    i_sfr_wr <= 1;
    @(posedge i_clk);
    i_sfr_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    @(posedge i_clk);
    i_sfr_addr <= ad;
    repeat (2) @(posedge i_clk);
    #1 v = o_sfr_rdata;
  endtask : rd
  task automatic wt(input logic b);
    @(posedge i_clk);
    i_sfr_addr <= 8'hD5;
    @(posedge i_clk);
    #1;
    for (int i = 0; i < 300 && o_sfr_rdata[7] !== b; i++) @(posedge i_clk) #1;
    chk("idle", {7'h0, b}, {7'h0, o_sfr_rdata[7]});
  endtask : wt
  task automatic prd(input logic [7:0] ad, input logic s);
    @(posedge i_clk);
    i_prog_addr <= ad;
    i_prog_sig <= s;
    i_prog_rd <= 1;
    @(posedge i_clk);
    i_prog_rd <= 0;
    #1 v = o_prog_rdata;
  endtask : prd
  task automatic vf(input logic [15:0] ad, input logic [7:0] e);
    wr(8'hD5, 8'h03, 1);
    wr(8'hD6, ad[15:8], 0);
    wr(8'hD6, ad[7:0], 0);
    repeat (4) @(posedge i_clk);
    rd(8'hD6);
    chk("verify", e, v);
    wr(8'hD5, 8'h00, 1);
  endtask : vf
  task automatic pg(input logic [15:0] ad, input logic [7:0] dt, input logic f);
    wr(8'hD5, 8'h0B, 1);
    wr(8'hD6, ad[15:8], 0);
    wr(8'hD6, ad[7:0], 0);
    wr(8'hD6, dt, 0);
    wt(0);
    wr(8'hD5, 8'h0E, 1);
    inj <= f;
    wt(1);
    inj <= 0;
    rd(8'hD5);
    chk("status", st(1, f, 4'hB), v);
    wr(8'hD5, 8'h00, 1);
  endtask : pg
  task automatic sq(input logic [7:0] c, input logic [7:0] b1, input logic [7:0] b2, input int n);
    wr(8'hD5, c, 1);
    if (n > 0) wr(8'hD6, b1, 0);
    if (n > 1) wr(8'hD6, b2, 0);
    repeat (40) @(posedge i_clk);
    wt(1);
    wr(8'hD5, 8'h00, 1);
  endtask : sq
  always @(posedge i_clk) begin
    cyc++;
    i_external_access_pin <= cyc[4];
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    void'($urandom(72901));
    repeat (10) @(posedge i_clk);
    i_reset <= 0;
    i_power_on <= 0;
    rd(8'hD5);
    chk("reset", st(1, 0, 4'h0), v);
    wr(8'hD5, 8'h0B, 0);
    wr(8'hD5, 8'hC0, 1);
    wr(8'hD6, 8'h55, 0);
    rd(8'hD5);
    chk("untimed", st(1, 0, 4'h0), v);
    for (int i = 0; i < 3; i++) begin
      a = 16'h2000 + 16'(i) * 16'h0800 + 16'($urandom & 16'h07FF);
      d = 8'($urandom);
      pg(a, d, 0);
      chk("mem", d, i_mem.mem[a[12:0]]);
      vf(a, d);
    end
    pg(a, d, 1);
    rd(8'hD5);
    chk("cleared", st(1, 0, 4'h0), v);
    wr(8'hD5, 8'h0B, 1);
    wr(8'hD6, 8'h00, 0);
    wr(8'hD6, d, 0);
    wr(8'hD6, d, 0);
    rd(8'hD5);
    chk("range", st(1, 1, 4'hB), v);
    wr(8'hD5, 8'h00, 1);
    sq(8'h0E, 8'h00, 8'h00, 0);
    chk("erase", 8'hFF, i_mem.mem[a[12:0]]);
    sq(8'h09, 8'hF7, 8'h00, 1);
    chk("wdt", 8'h01, {7'h0, o_wdt_por_enable});
    wr(8'hD5, 8'h01, 1);
    rd(8'hD6);
    chk("option", 8'hF7, v);
    wr(8'hD5, 8'h00, 1);
    sq(8'h0A, 8'h00, 8'h0F, 2);
    i_parallel_mode <= 1;
    i_prog_code_data <= d;
    prd(8'h00, 0);
    chk("encrypt", xn(d, 8'h0F), v);
    chk("open", 8'h01, {5'h0, o_block_ext_code_read, o_block_ext_data_read, o_prog_write_ok});
    for (int i = 0; i < 4; i++) begin
      i_loader_mode <= i[0];
      i_parallel_mode <= !i[0];
      prd(sa[i], 1);
      chk("sig", se[i], v);
    end
    sq(8'h0C, 8'h00, 8'h00, 0);
    chk("wdt_erased", 8'h00, {7'h0, o_wdt_por_enable});
    sq(8'h0A, 8'h40, 8'hEF, 2);
    prd(8'h00, 0);
    chk("locked", 8'hFF, v);
    chk("lock", 8'h06, {5'h0, o_block_ext_code_read, o_block_ext_data_read, o_prog_write_ok});
    i_parallel_mode <= 0;
    i_loader_mode <= 0;
    wr(8'hD5, 8'h02, 1);
    wr(8'hD6, 8'h40, 0);
    rd(8'hD6);
    chk("secver", 8'hEF, v);
    wr(8'hD5, 8'h00, 1);
    vf(a, xn(8'hFF, a[5:0] == 6'h00 ? 8'h0F : 8'hFF));
    sq(8'h0D, 8'h00, 8'h00, 0);
    chk("unlock", 8'h00, {6'h0, o_block_ext_code_read, o_block_ext_data_read});
    wr(8'hD5, 8'h0F, 1);
    #1 chk("sysrst", 8'h01, {7'h0, srq});
    @(posedge i_clk) i_reset <= 1;
    repeat (2) @(posedge i_clk);
    i_reset <= 0;
    rd(8'hD5);
    chk("rst2", st(1, 0, 4'h0), v);
    conclude();
  end
endmodule : flash_iap_security_sequencer_tb_top
